// *** shared/mrs_pkg.sv ***
// Package for the fifth/sixth mode-register block of the DRAM device.
// Assumes one clock (mclk) and command pins sampled on its rising edge.
`default_nettype none
package mrs_pkg;
   // ==========================================================
   // Command pins covered by the check bit
   typedef struct packed {
      logic        act_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [1:0]  bg;
      logic [1:0]  ba;
      logic        a17;
      logic [13:0] a;
   } mrs_cmd_s;

   typedef struct packed {
      logic     valid;
      logic     par_ok;
      mrs_cmd_s cmd;
   } mrs_stage_s;

   // ==========================================================
   // Mode-register select codes and layout
   localparam logic [2:0] SEL_MR5       = 3'h5;
   localparam logic [2:0] SEL_MR6       = 3'h6;
   localparam int         MR_W          = 22;
   localparam logic [21:0] MR5_RESET    = 22'h000000;
   localparam logic [21:0] MR6_RESET    = 22'h000000;

   // Fifth register fields
   localparam int MR5_RDBI_BIT    = 12;
   localparam int MR5_WDBI_BIT    = 11;
   localparam int MR5_DM_BIT      = 10;
   localparam int MR5_PERSIST_BIT = 9;
   localparam int MR5_PARK_LSB    = 6;
   localparam int MR5_ODTBUF_BIT  = 5;
   localparam int MR5_PARERR_BIT  = 4;
   localparam int MR5_CRCERR_BIT  = 3;
   localparam int MR5_PL_LSB      = 0;

   // Sixth register fields
   localparam int MR6_RATE_LSB    = 10;
   localparam int MR6_VREF_EN_BIT = 7;
   localparam int MR6_RANGE_BIT   = 6;
   localparam int MR6_VALUE_LSB   = 0;
   localparam logic [2:0] RATE_MAX_CODE   = 3'h4;
   localparam logic [5:0] VREF_STEP_COUNT = 6'h32;

   // Check-bit latency codes and their clock counts
   localparam logic [2:0] PL_OFF   = 3'h0;
   localparam logic [2:0] PL_4     = 3'h1;
   localparam logic [2:0] PL_5     = 3'h2;
   localparam logic [2:0] PL_6     = 3'h3;
   localparam logic [2:0] PL_4_CYC = 3'h4;
   localparam logic [2:0] PL_5_CYC = 3'h5;
   localparam logic [2:0] PL_6_CYC = 3'h6;
   localparam int         PIPE_D   = 7;
endpackage : mrs_pkg
`default_nettype wire

// *** verilog/mrs_parity_check.sv ***
// Even-parity check of one sampled command against its check bit.
// Assumes the struct holds exactly the covered pins.
`default_nettype none
module mrs_parity_check (
   // Sampled command
   input  wire mrs_pkg::mrs_cmd_s cmd,
   input  wire logic              par,
   // Result
   output logic                   ok
);
   // Clock enable, termination and select pins are not in the struct
   assign ok = ~(^{cmd, par});
endmodule : mrs_parity_check
`default_nettype wire

// *** verilog/mrs_mode_regs.sv ***
// Fifth and sixth mode registers with check-bit latency and error flags.
// Assumes the controller drives pins synchronous to mclk; crc_error and
// power_down come from the CRC and power-down logic elsewhere in the device.
`default_nettype none
// Operation
// - Buffer off in power-down: ignore pin, no nominal, parked may apply.
// - Parity error sets flag; stays set until a register write clears it.
// - Write CRC error sets flag; stays set until a register write clears it.
// - Parity checking off by default, on only with nonzero latency.
// - With checking on, a command executes only if its parity is good.
// - Parity covers command lines and whole address incl. bank, group.
// - Clock enable, termination and select pins excluded from parity.
// - Sixth register loaded by register-set with select field 110.
// - Bits 12:10 select data-rate band; codes 101 to 111 reserved.
// - Bit 7 training enable, bit 6 range, bits 5:0 step value.
// - Latency code 0 off, 1..3 give four to six clocks, rest reserved.
// - Without persistent mode checking pauses while parity flag set.
// - Fifth register bit 4 parity flag, bit 3 CRC flag.
// - Fifth register bit 5 keeps buffer on at 0, off at 1.
module mrs_mode_regs (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // Command and address pins
   input  wire logic              cke,
   input  wire logic              cs_n,
   input  wire mrs_pkg::mrs_cmd_s cmd,
   input  wire logic              par,
   // Termination and power state
   input  wire logic              odt,
   input  wire logic              power_down,
   // Write CRC checker result
   input  wire logic              crc_error,
   // Executed command
   output mrs_pkg::mrs_cmd_s      exec_cmd_q,
   output logic                   exec_valid_q,
   output logic                   par_error_q,
   // Register contents
   output logic [21:0]            mode_register_five_q,
   output logic [21:0]            mode_register_six_q,
   // Decoded settings
   output logic                   nominal_termination_q,
   output logic                   parked_termination_q,
   output logic [2:0]             rate_band_q,
   output logic                   rate_reserved_q,
   output logic                   vref_train_en_q,
   output logic                   vref_range_q,
   output logic [5:0]             data_input_reference_level_q,
   output logic                   vref_value_valid_q
);
   // ==========================================================
   // Sampling and latency pipeline
   mrs_pkg::mrs_stage_s pipe_q [mrs_pkg::PIPE_D];
   mrs_pkg::mrs_stage_s tap;
   logic                par_ok;
   logic [2:0]          lat_cyc;
   logic                check_on;
   logic                is_mrs;
   logic [21:0]         mrs_word;
   logic [2:0]          mrs_sel;
   logic                par_fail;
   logic                do_exec;

   mrs_parity_check u_check (
      .cmd (cmd),
      .par (par),
      .ok  (par_ok)
   );

   // Reserved latency codes behave as disabled
   always_comb begin
      case (mode_register_five_q[mrs_pkg::MR5_PL_LSB +: 3])
         mrs_pkg::PL_4: lat_cyc = mrs_pkg::PL_4_CYC;
         mrs_pkg::PL_5: lat_cyc = mrs_pkg::PL_5_CYC;
         mrs_pkg::PL_6: lat_cyc = mrs_pkg::PL_6_CYC;
         default:       lat_cyc = 3'h0;
      endcase
   end

   // Checking needs a latency; flag pauses it unless persistent
   assign check_on = (lat_cyc != 3'h0) &&
                     (!mode_register_five_q[mrs_pkg::MR5_PARERR_BIT] ||
                      mode_register_five_q[mrs_pkg::MR5_PERSIST_BIT]);

   // Stage 0 holds the newest command; deselected cycles carry no command
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < mrs_pkg::PIPE_D; i++) begin
            pipe_q[i] <= '0;
         end
      end else begin
         pipe_q[0].valid  <= cke & ~cs_n;
         pipe_q[0].par_ok <= par_ok;
         pipe_q[0].cmd    <= cmd;
         for (int i = 1; i < mrs_pkg::PIPE_D; i++) begin
            pipe_q[i] <= pipe_q[i-1];
            // Tapped command is spent, so a longer latency cannot rerun it
            if (i - 1 == int'(lat_cyc)) begin
               pipe_q[i].valid <= 1'b0;
            end
         end
      end
   end

   // Latency change mid-flight may still skip a queued command;
   // controller is expected to idle around such a write
   assign tap      = pipe_q[lat_cyc];
   assign par_fail = tap.valid && check_on && !tap.par_ok;
   assign do_exec  = tap.valid && !par_fail;

   // ==========================================================
   // Register-set decode
   assign is_mrs = do_exec && tap.cmd.act_n &&
                   !tap.cmd.ras_n && !tap.cmd.cas_n && !tap.cmd.we_n;
   assign mrs_word = {tap.cmd.bg, tap.cmd.ba, tap.cmd.a17, 3'h0, tap.cmd.a};
   assign mrs_sel  = mrs_word[20:18];

   always_ff @(posedge mclk) begin
      if (rst) begin
         exec_valid_q <= 1'b0;
         exec_cmd_q   <= '0;
         par_error_q  <= 1'b0;
      end else begin
         exec_valid_q <= do_exec;
         exec_cmd_q   <= tap.cmd;
         par_error_q  <= par_fail;
      end
   end

   // ==========================================================
   // Fifth register; writing 0 clears a flag, a new error wins
   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_register_five_q <= mrs_pkg::MR5_RESET;
      end else begin
         if (is_mrs && mrs_sel == mrs_pkg::SEL_MR5) begin
            mode_register_five_q <= mrs_word;
            mode_register_five_q[mrs_pkg::MR5_PARERR_BIT] <=
               mode_register_five_q[mrs_pkg::MR5_PARERR_BIT] & mrs_word[mrs_pkg::MR5_PARERR_BIT];
            mode_register_five_q[mrs_pkg::MR5_CRCERR_BIT] <=
               mode_register_five_q[mrs_pkg::MR5_CRCERR_BIT] & mrs_word[mrs_pkg::MR5_CRCERR_BIT];
         end
         if (par_fail) begin
            mode_register_five_q[mrs_pkg::MR5_PARERR_BIT] <= 1'b1;
         end
         if (crc_error) begin
            mode_register_five_q[mrs_pkg::MR5_CRCERR_BIT] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Sixth register; stored whole, reserved bits kept as written
   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_register_six_q <= mrs_pkg::MR6_RESET;
      end else if (is_mrs && mrs_sel == mrs_pkg::SEL_MR6) begin
         mode_register_six_q <= mrs_word;
      end
   end

   // ==========================================================
   // Decoded rate band, registered so every output is a flop
   // Reserved codes are flagged, not corrected; the controller owns the rate
   always_ff @(posedge mclk) begin
      if (rst) begin
         rate_band_q     <= 3'h0;
         rate_reserved_q <= 1'b0;
      end else begin
         rate_band_q     <= mode_register_six_q[mrs_pkg::MR6_RATE_LSB +: 3];
         rate_reserved_q <= mode_register_six_q[mrs_pkg::MR6_RATE_LSB +: 3] > mrs_pkg::RATE_MAX_CODE;
      end
   end

   // ==========================================================
   // Decoded reference-level training settings
   // Steps from fifty upward are flagged as out of range
   always_ff @(posedge mclk) begin
      if (rst) begin
         vref_train_en_q              <= 1'b0;
         vref_range_q                 <= 1'b0;
         data_input_reference_level_q <= 6'h00;
         vref_value_valid_q           <= 1'b1;
      end else begin
         vref_train_en_q <= mode_register_six_q[mrs_pkg::MR6_VREF_EN_BIT];
         vref_range_q    <= mode_register_six_q[mrs_pkg::MR6_RANGE_BIT];
         data_input_reference_level_q <= mode_register_six_q[mrs_pkg::MR6_VALUE_LSB +: 6];
         vref_value_valid_q <=
            mode_register_six_q[mrs_pkg::MR6_VALUE_LSB +: 6] < mrs_pkg::VREF_STEP_COUNT;
      end
   end

   // ==========================================================
   // Nominal termination: pin is ignored when buffer is off in power-down
   always_ff @(posedge mclk) begin
      if (rst) begin
         nominal_termination_q <= 1'b0;
      end else if (power_down && mode_register_five_q[mrs_pkg::MR5_ODTBUF_BIT]) begin
         nominal_termination_q <= 1'b0;
      end else begin
         nominal_termination_q <= odt;
      end
   end

   // ==========================================================
   // Parked termination: only with a nonzero parked code
   always_ff @(posedge mclk) begin
      if (rst) begin
         parked_termination_q <= 1'b0;
      end else if (power_down && mode_register_five_q[mrs_pkg::MR5_ODTBUF_BIT]) begin
         parked_termination_q <= mode_register_five_q[mrs_pkg::MR5_PARK_LSB +: 3] != 3'h0;
      end else begin
         parked_termination_q <= !odt && mode_register_five_q[mrs_pkg::MR5_PARK_LSB +: 3] != 3'h0;
      end
   end
endmodule : mrs_mode_regs
`default_nettype wire

// *** bench/mrs_mode_regs_properties.sv ***
// Checker for the fifth/sixth mode-register block.
// Assumes it is bound to mrs_mode_regs and sees only its ports.
`default_nettype none
module mrs_mode_regs_chk (
   // Clock, reset and pins
   input wire logic              mclk,
   input wire logic              rst,
   input wire logic              cke,
   input wire logic              cs_n,
   input wire mrs_pkg::mrs_cmd_s cmd,
   input wire logic              par,
   input wire logic              odt,
   input wire logic              power_down,
   input wire logic              crc_error,
   // Outputs
   input wire mrs_pkg::mrs_cmd_s exec_cmd_q,
   input wire logic              exec_valid_q,
   input wire logic              par_error_q,
   input wire logic [21:0]       mode_register_five_q,
   input wire logic [21:0]       mode_register_six_q,
   input wire logic              nominal_termination_q,
   input wire logic              parked_termination_q,
   input wire logic [2:0]        rate_band_q,
   input wire logic              rate_reserved_q,
   input wire logic              vref_train_en_q,
   input wire logic              vref_range_q,
   input wire logic [5:0]        data_input_reference_level_q,
   input wire logic              vref_value_valid_q
);
   logic        take, bad, chk_on, ex6;
   logic [2:0]  pl;
   logic [1:0]  fl;
   logic [21:0] m5, m6;
   assign m5 = mode_register_five_q;
   assign m6 = mode_register_six_q;
   assign take = cke && !cs_n;
   assign bad = ^{cmd, par};
   assign pl = m5[2:0];
   assign fl = m5[4:3];
   assign chk_on = !m5[4] || m5[9];
   assign ex6 = exec_valid_q && exec_cmd_q.act_n && !exec_cmd_q.ras_n && !exec_cmd_q.cas_n && !exec_cmd_q.we_n
                && {exec_cmd_q.bg[0], exec_cmd_q.ba} == 3'h6;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   // ==========================================================
   // Flags, check-bit latency and refusal
   crc_flag_set_a: assert property (crc_error |=> m5[3])
      else $error("crc flag not set");
   flags_hold_a: assert property (!exec_valid_q |-> (fl & $past(fl)) == $past(fl))
      else $error("flag dropped without write");
   par_flag_set_a: assert property (par_error_q |-> m5[4])
      else $error("parity flag not set");
   off_exec_a: assert property (take && pl == 3'h0 ##1 pl == 3'h0 |=> exec_valid_q && !par_error_q)
      else $error("command lost with checking off");
   lat_four_a: assert property (take && pl == 3'h1 |=>
      (!exec_valid_q && !par_error_q)[*5] ##1 (exec_valid_q || par_error_q)) else $error("latency four wrong");
   drop_bad_a: assert property (take && bad && pl == 3'h2 && chk_on |-> ##7 par_error_q && !exec_valid_q)
      else $error("bad command not dropped");
   pause_set_a: assert property (take && bad && pl == 3'h2 && !chk_on |-> ##7 exec_valid_q)
      else $error("checking not paused");
   // ==========================================================
   // Sixth register and decoded settings
   mr6_load_a: assert property (ex6 |->
      m6 == {exec_cmd_q.bg, exec_cmd_q.ba, exec_cmd_q.a17, 3'h0, exec_cmd_q.a}) else $error("sixth not loaded");
   mr6_keep_a: assert property (!ex6 |-> $stable(m6))
      else $error("sixth changed");
   setting_decode_a: assert property (1'b1 |=>
      {rate_band_q, rate_reserved_q, vref_train_en_q, vref_range_q, data_input_reference_level_q, vref_value_valid_q}
      == {$past(m6[12:10]), $past(m6[12:10]) > 3'h4, $past(m6[7:0]), $past(m6[5:0]) < 6'h32}) else $error("decode");
   term_off_a: assert property (power_down && m5[5] |=>
      !nominal_termination_q && parked_termination_q == ($past(m5[8:6]) != 3'h0)) else $error("termination off");
   term_on_a: assert property (!(power_down && m5[5]) |=> nominal_termination_q == $past(odt))
      else $error("nominal termination");
endmodule : mrs_mode_regs_chk
bind mrs_mode_regs mrs_mode_regs_chk i_chk (.mclk, .rst, .cke, .cs_n, .cmd, .par, .odt, .power_down, .crc_error,
   .exec_cmd_q, .exec_valid_q, .par_error_q, .mode_register_five_q, .mode_register_six_q, .nominal_termination_q,
   .parked_termination_q, .rate_band_q, .rate_reserved_q, .vref_train_en_q, .vref_range_q,
   .data_input_reference_level_q, .vref_value_valid_q);
`default_nettype wire

// *** bench/mrs_host.sv ***
// Controller model driving the command pins of the mode-register block.
// Assumes one clock; all pins change on its falling edge.
`default_nettype none
module mrs_host (
   // Clock
   input  wire logic        mclk,
   // Command pins
   output logic             cke,
   output logic             cs_n,
   output mrs_pkg::mrs_cmd_s cmd,
   output logic             par,
   output logic             odt
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cke = 1'b1;
      cs_n = 1'b1;
      cmd = '0;
      par = 1'b0;
      odt = 1'b0;
   end
   function automatic mrs_pkg::mrs_cmd_s mrs(input logic [21:0] w);
      return {1'b1, 3'h0, w[21:18], w[17], w[13:0]};
   endfunction : mrs
   task automatic issue(input mrs_pkg::mrs_cmd_s c, input logic bad, input logic en);
      @(negedge mclk);
      cke <= en;
      cs_n <= 1'b0;
      cmd <= c;
      par <= ^c ^ bad;
   endtask : issue
   // Deselected lines flip so a stale command is never reread
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge mclk);
         cke <= 1'b1;
         cs_n <= 1'b1;
         cmd <= ~cmd;
         par <= ~par;
      end
   endtask : idle
   task automatic term(input logic v);
      @(negedge mclk);
      odt <= v;
   endtask : term
endmodule : mrs_host
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the fifth/sixth mode-register block.
// Assumes the controller model drives the pins; device events come from here.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic              mclk = 1'b0, rst, power_down, crc_error;
   logic              cke, cs_n, par, odt, ex_v, pe, nom, park, rres, ten, trng, vok;
   mrs_pkg::mrs_cmd_s cmd, ex_cmd, last_ex;
   logic [21:0]       m5, m6, e6;
   logic [2:0]        band;
   logic [5:0]        lvl;
   int                err_count = 0, samples_checked = 0, cyc = 0, perr_cnt = 0;
   always #10 mclk = ~mclk;
   mrs_host u_host (.mclk(mclk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .par(par), .odt(odt));
   mrs_mode_regs i_dut (.mclk(mclk), .rst(rst), .cke(cke), .cs_n(cs_n), .cmd(cmd), .par(par), .odt(odt),
      .power_down(power_down), .crc_error(crc_error), .exec_cmd_q(ex_cmd), .exec_valid_q(ex_v), .par_error_q(pe),
      .mode_register_five_q(m5), .mode_register_six_q(m6), .nominal_termination_q(nom), .parked_termination_q(park),
      .rate_band_q(band), .rate_reserved_q(rres), .vref_train_en_q(ten), .vref_range_q(trng),
      .data_input_reference_level_q(lvl), .vref_value_valid_q(vok));
   // Pulses are looked at on the falling edge, where they have settled
   always @(negedge mclk) begin
      if (ex_v) begin
         last_ex = ex_cmd;
      end
      if (pe) begin
         perr_cnt++;
      end
   end
   task automatic chk_reg(input logic [22:0] got, input logic [22:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask : chk_reg
   // Long idle covers the six-clock latency plus pipeline
   task automatic wr(input logic [21:0] w, input logic bad);
      u_host.issue(u_host.mrs(w), bad, 1'b1);
      u_host.idle(12);
   endtask : wr
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      rst = 1'b1;
      power_down = 1'b0;
      crc_error = 1'b0;
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      chk_reg(m5, 22'h000000);
      // ==========================================================
      // Every rate code; first write has a bad check bit
      for (int i = 0; i < 8; i++) begin
         e6 = {9'h0c0, 3'(i), 4'h3, 6'(i * 7)};
         wr(e6, i == 0);
         chk_reg(m6, e6);
         chk_reg(last_ex, u_host.mrs(e6));
         chk_reg({rres, ten, trng, band, lvl, vok}, {i > 4, 2'h3, 3'(i), 6'(i * 7), 1'b1});
      end
      wr(22'h1800b2, 1'b0);
      chk_reg({trng, vok}, 2'h0);
      // ==========================================================
      // Other selects, other commands, clock enable low
      for (int s = 0; s < 8; s++) begin
         if (s != 6) begin
            wr({1'b0, 3'(s), 18'h3ffff}, 1'b0);
         end
      end
      chk_reg(m5[4:3], 2'h0);
      u_host.issue(u_host.mrs(22'h1bffff) ^ 23'h400000, 1'b0, 1'b1);
      u_host.issue(u_host.mrs(22'h1bffff) ^ 23'h080000, 1'b0, 1'b1);
      u_host.issue(u_host.mrs(22'h1bffff), 1'b0, 1'b0);
      u_host.idle(12);
      chk_reg(m6, 22'h1800b2);
      // ==========================================================
      // Write CRC flag: set, kept by writing one, cleared by zero
      @(negedge mclk) crc_error = 1'b1;
      @(negedge mclk) crc_error = 1'b0;
      @(negedge mclk);
      chk_reg(m5[3], 1'b1);
      wr(22'h140008, 1'b0);
      chk_reg(m5[3], 1'b1);
      wr(22'h140000, 1'b0);
      chk_reg(m5[3], 1'b0);
      // ==========================================================
      // Latency codes with flag pause and persistent mode
      for (int l = 1; l < 5; l++) begin
         wr({4'h5, 15'h0, 3'(l)}, 1'b0);
         wr(22'h180080, 1'b1);
         chk_reg(m5[4], l != 4);
         chk_reg(m6, l == 4 ? 22'h180080 : (l == 1 ? 22'h1800b2 : 22'h180081));
         wr(22'h180081, 1'b1);
         chk_reg(m6, 22'h180081);
         wr({4'h5, 8'h0, 1'b1, 6'h0, 3'(l)}, 1'b0);
         chk_reg(m5[4], 1'b0);
         wr(22'h180082, 1'b1);
         wr(22'h180083, 1'b1);
         chk_reg({m5[4], m6}, l == 4 ? 23'h180083 : 23'h580081);
      end
      chk_reg(23'(perr_cnt), 23'h000009);
      // ==========================================================
      // Termination with buffer off in power-down
      wr({4'h5, 9'h0, 3'h2, 1'b1, 5'h0}, 1'b0);
      u_host.term(1'b1);
      power_down = 1'b1;
      repeat (2) @(negedge mclk);
      chk_reg({nom, park}, 2'h1);
      power_down = 1'b0;
      repeat (2) @(negedge mclk);
      chk_reg({nom, park}, 2'h2);
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
